// >>> rtl/bstp_pkg.sv
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: test clock domain for the tap, core_clk domain for pin qualification
// Notes: instruction codes, chain layout and tap state codes live here
package bstp_pkg;
    // instruction codes
    localparam logic [7:0] BSTP_IR_EXTEST = 8'h00;
    localparam logic [7:0] BSTP_IR_SAMPLE = 8'h40;
    localparam logic [7:0] BSTP_IR_IDCODE = 8'h55;
    localparam logic [7:0] BSTP_IR_CLAMP = 8'hd0;
    localparam logic [7:0] BSTP_IR_HIGHZ = 8'h80;
    localparam logic [7:0] BSTP_IR_BYPASS = 8'hff;
    localparam logic [7:0] BSTP_IR_RESET = 8'h55;
    // value loaded into the instruction shifter on capture-ir
    localparam logic [7:0] BSTP_IR_CAPTURE = 8'h01;
    localparam int BSTP_IR_W = 8;
    localparam int BSTP_ID_W = 32;
    // chain layout: pin p (p < last) uses input 3p+3, enable 3p+4, output 3p+5
    localparam int BSTP_CHAIN_LEN = 382;
    localparam int BSTP_NUM_PINS = 126;
    localparam int BSTP_CELL_FIRST = 3;
    localparam int BSTP_CELL_STRIDE = 3;
    localparam int BSTP_MODE_OUT_BIT = 381;
    localparam int BSTP_MODE_OE_BIT = 380;
    localparam int BSTP_MODE_IN_BIT = 379;
    // sixteen tap states, codes as usually published for the tap
    typedef enum logic [3:0] {
        BSTP_TLR = 4'hf,
        BSTP_RTI = 4'hc,
        BSTP_SDS = 4'h7,
        BSTP_CDR = 4'h6,
        BSTP_SDR = 4'h2,
        BSTP_E1D = 4'h1,
        BSTP_PDR = 4'h3,
        BSTP_E2D = 4'h0,
        BSTP_UDR = 4'h5,
        BSTP_SIS = 4'h4,
        BSTP_CIR = 4'he,
        BSTP_SIR = 4'ha,
        BSTP_E1I = 4'h9,
        BSTP_PIR = 4'hb,
        BSTP_E2I = 4'h8,
        BSTP_UIR = 4'hd
    } bstp_state_e;
    // data register selected by the current instruction
    typedef enum logic [1:0] {
        BSTP_SEL_BYP = 2'h0,
        BSTP_SEL_ID = 2'h1,
        BSTP_SEL_BSR = 2'h3
    } bstp_sel_e;
endpackage

// >>> rtl/bstp_tap.sv
// Purpose: tap controller state machine of the boundary-scan test port
// Assumes: tck from the external tester, trst_n asynchronous, active low
// Notes: hold_reset parks the machine in test-logic-reset while scan is off
`timescale 1ns/1ns
`default_nettype none
module bstp_tap (
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic hold_reset,
    output bstp_pkg::bstp_state_e state
);
    import bstp_pkg::*;

    typedef struct packed {
        bstp_state_e st;
    } bstp_tap_s;

    bstp_tap_s tap_r;
    bstp_tap_s tap_nxt;

    // sixteen-state walk steered by tms on each rising tck
    always_comb begin
        tap_nxt = tap_r;
        unique case (tap_r.st)
            BSTP_TLR: tap_nxt.st = tms ? BSTP_TLR : BSTP_RTI;
            BSTP_RTI: tap_nxt.st = tms ? BSTP_SDS : BSTP_RTI;
            BSTP_SDS: tap_nxt.st = tms ? BSTP_SIS : BSTP_CDR;
            BSTP_CDR: tap_nxt.st = tms ? BSTP_E1D : BSTP_SDR;
            BSTP_SDR: tap_nxt.st = tms ? BSTP_E1D : BSTP_SDR;
            BSTP_E1D: tap_nxt.st = tms ? BSTP_UDR : BSTP_PDR;
            BSTP_PDR: tap_nxt.st = tms ? BSTP_E2D : BSTP_PDR;
            BSTP_E2D: tap_nxt.st = tms ? BSTP_UDR : BSTP_SDR;
            BSTP_UDR: tap_nxt.st = tms ? BSTP_SDS : BSTP_RTI;
            BSTP_SIS: tap_nxt.st = tms ? BSTP_TLR : BSTP_CIR;
            BSTP_CIR: tap_nxt.st = tms ? BSTP_E1I : BSTP_SIR;
            BSTP_SIR: tap_nxt.st = tms ? BSTP_E1I : BSTP_SIR;
            BSTP_E1I: tap_nxt.st = tms ? BSTP_UIR : BSTP_PIR;
            BSTP_PIR: tap_nxt.st = tms ? BSTP_E2I : BSTP_PIR;
            BSTP_E2I: tap_nxt.st = tms ? BSTP_UIR : BSTP_SIR;
            BSTP_UIR: tap_nxt.st = tms ? BSTP_SDS : BSTP_RTI;
        endcase
        // scan disabled keeps the tap out of the way of the pins
        if (hold_reset) begin
            tap_nxt.st = BSTP_TLR;
        end
    end

    // trst_n forces test-logic-reset at once, without waiting for tck
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tap_r.st <= BSTP_TLR;
        end else begin
            tap_r <= tap_nxt;
        end
    end

    assign state = tap_r.st;
endmodule
`default_nettype wire

// >>> rtl/bstp_top.sv
// Purpose: boundary-scan test port: instruction, id, bypass and pin chain
// Assumes: tck, tms, tdi, trst_n come from the board tester, tck at 50 percent duty
// Notes: test registers are reached only by shifting; there is no cpu port
`timescale 1ns/1ns
`default_nettype none
module bstp_top #(
    parameter logic [31:0] ID_VALUE = 32'h1234_5001, // arbitrary neutral value
    parameter int NUM_PINS = bstp_pkg::BSTP_NUM_PINS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_reset_pin,
    input wire logic scan_enable_pin,
    input wire logic emulator_enable_pin,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    output logic test_pins_owned,
    input wire logic [NUM_PINS-1:0] sys_out,
    input wire logic [NUM_PINS-1:0] sys_oe,
    output logic [NUM_PINS-1:0] sys_in,
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe
);
    import bstp_pkg::*;

    // which data register an instruction puts on the serial path
    function automatic bstp_sel_e dr_select(input logic [7:0] code);
        bstp_sel_e sel;
        sel = BSTP_SEL_BYP;
        unique case (code)
            BSTP_IR_IDCODE: sel = BSTP_SEL_ID;
            BSTP_IR_EXTEST, BSTP_IR_SAMPLE: sel = BSTP_SEL_BSR;
            // clamp and highz keep the chain still and route through bypass
            BSTP_IR_CLAMP, BSTP_IR_HIGHZ: sel = BSTP_SEL_BYP;
            default: sel = BSTP_SEL_BYP; // reserved codes behave as bypass
        endcase
        return sel;
    endfunction

    // instructions under which the chain latches drive the pads
    function automatic logic drives_pins(input logic [7:0] code);
        return (code == BSTP_IR_EXTEST) || (code == BSTP_IR_CLAMP);
    endfunction

    // chain position of the input cell of a pin; enable and output follow it
    function automatic int cell_in(input int p);
        int pos;
        pos = BSTP_CELL_FIRST + BSTP_CELL_STRIDE * p;
        if (p == NUM_PINS - 1) begin
            pos = BSTP_MODE_IN_BIT; // mode pin sits at the top of the chain
        end
        return pos;
    endfunction

    // chain position of the output-enable cell of a pin
    function automatic int cell_oe(input int p);
        return cell_in(p) + 1;
    endfunction

    // chain position of the output cell of a pin
    function automatic int cell_out(input int p);
        return cell_in(p) + 2;
    endfunction

    // how the two domains meet:
    // - the three enabling pins are sampled on core_clk, each through two flops,
    //   and only their combined, registered level crosses into the tck domain
    // - the tck side sees that level through two more flops, so the tap leaves
    //   test-logic-reset only a few tck edges after the pins allow it
    // - tck stops between frames, so the tck-side synchronisers move only while
    //   the tester clocks; a tester must give a few idle clocks after enabling
    // - pad levels are resampled on tck, so a captured input cell shows the pad
    //   as it stood two tck edges before capture-dr
    // - sys_out and sys_oe are taken at capture-dr without a synchroniser; the
    //   core is expected to hold them still while a snapshot is taken
    // - the chain latches drive the pads combinationally; pads are settled only
    //   once update-dr has completed
    // chain map: pin p below the last uses input 3p+3, enable 3p+4, output 3p+5,
    // the mode pin uses 379, 380 and 381; the remaining positions still shift

    // core_clk side: each enabling pin has a two-flop synchroniser of its own
    typedef struct packed {
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic act;
    } bstp_core_s;

    // tck side: all test registers and the synchronisers into that domain;
    // none of them has a processor-bus port, shifting is the only access
    typedef struct packed {
        logic [BSTP_IR_W-1:0] ir_sh;
        logic [BSTP_IR_W-1:0] ir;
        logic [BSTP_ID_W-1:0] id_sh;
        logic byp;
        logic [BSTP_CHAIN_LEN-1:0] bsr_sh;
        logic [BSTP_CHAIN_LEN-1:0] bsr_lat;
        logic [NUM_PINS-1:0] pad_s1;
        logic [NUM_PINS-1:0] pad_s2;
        logic en_s1;
        logic en_s2;
    } bstp_test_s;

    bstp_core_s core_r;
    bstp_core_s core_nxt;
    bstp_test_s tst_r;
    bstp_test_s tst_nxt;
    bstp_state_e state;
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_oe_r;
    logic tdo_oe_nxt;
    logic scan_on;
    logic [2:0] raw_pins;
    logic pins_driven;
    logic pins_floated;

    // the three pins are asynchronous to both clocks; no gate sits before the flops
    assign raw_pins = {chip_reset_pin, scan_enable_pin, emulator_enable_pin};

    // only second stages are combined, so an unsettled first stage never reaches act
    always_comb begin
        core_nxt = core_r;
        core_nxt.pin_s1 = raw_pins;
        core_nxt.pin_s2 = core_r.pin_s1;
        core_nxt.act = core_r.pin_s2[2] & core_r.pin_s2[1] & ~core_r.pin_s2[0];
    end

    // synchronous reset on core_clk
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_r <= '0;
        end else begin
            core_r <= core_nxt;
        end
    end

    // pin ownership seen by the pin multiplexer of the chip
    assign test_pins_owned = core_r.act;

    // tap held in reset until the enable has crossed into the tck domain
    bstp_tap u_tap (
        .tck(tck),
        .trst_n(trst_n),
        .tms(tms),
        .hold_reset(~tst_r.en_s2),
        .state(state)
    );

    assign scan_on = tst_r.en_s2;

    // next value of every test register, one process for the whole domain
    always_comb begin
        tst_nxt = tst_r;
        // level crossing of the enable from core_clk into tck
        tst_nxt.en_s1 = core_r.act;
        tst_nxt.en_s2 = tst_r.en_s1;
        // pad levels are resynchronised to tck before any cell samples them
        tst_nxt.pad_s1 = pad_in;
        tst_nxt.pad_s2 = tst_r.pad_s1;
        unique case (state)
            // test-logic-reset reloads the identification instruction
            BSTP_TLR: begin
                tst_nxt.ir = BSTP_IR_RESET;
            end
            // capture-ir loads the fixed pattern a tester checks first
            BSTP_CIR: begin
                tst_nxt.ir_sh = BSTP_IR_CAPTURE;
            end
            BSTP_SIR: begin
                // shift toward bit 0, tdi enters at the top
                tst_nxt.ir_sh = {tdi, tst_r.ir_sh[BSTP_IR_W-1:1]};
            end
            // update-ir makes the shifted code the live instruction
            BSTP_UIR: begin
                tst_nxt.ir = tst_r.ir_sh;
            end
            // capture-dr loads the register that the instruction selects
            BSTP_CDR: begin
                unique case (dr_select(tst_r.ir))
                    BSTP_SEL_ID: begin
                        tst_nxt.id_sh = ID_VALUE;
                    end
                    BSTP_SEL_BSR: begin
                        // snapshot of system outputs and synchronised pads
                        for (int p = 0; p < NUM_PINS; p++) begin
                            tst_nxt.bsr_sh[cell_in(p)] = tst_r.pad_s2[p];
                            tst_nxt.bsr_sh[cell_oe(p)] = sys_oe[p];
                            tst_nxt.bsr_sh[cell_out(p)] = sys_out[p];
                        end
                    end
                    default: begin
                        // cleared so the first shift-dr clock shows low
                        tst_nxt.byp = 1'b0;
                    end
                endcase
            end
            // shift-dr moves the selected register one place toward tdo
            BSTP_SDR: begin
                unique case (dr_select(tst_r.ir))
                    BSTP_SEL_ID: begin
                        // id leaves least significant bit first
                        tst_nxt.id_sh = {tdi, tst_r.id_sh[BSTP_ID_W-1:1]};
                    end
                    BSTP_SEL_BSR: begin
                        tst_nxt.bsr_sh = {tdi, tst_r.bsr_sh[BSTP_CHAIN_LEN-1:1]};
                    end
                    default: begin
                        tst_nxt.byp = tdi;
                    end
                endcase
            end
            BSTP_UDR: begin
                // preload or extest update; clamp and highz keep the latches
                if (dr_select(tst_r.ir) == BSTP_SEL_BSR) begin
                    tst_nxt.bsr_lat = tst_r.bsr_sh;
                end
            end
            default: begin
                tst_nxt.ir = tst_r.ir;
            end
        endcase
    end

    // trst_n clears to constants; chain and bypass values carry no meaning
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tst_r <= '0;
            tst_r.ir <= BSTP_IR_RESET;
        end else begin
            tst_r <= tst_nxt;
        end
    end

    // serial output picks the shifter of the current path, bit 0 first
    always_comb begin
        tdo_nxt = 1'b0;
        tdo_oe_nxt = 1'b0;
        if (scan_on && (state == BSTP_SIR)) begin
            tdo_nxt = tst_r.ir_sh[0];
            tdo_oe_nxt = 1'b1;
        end else if (scan_on && (state == BSTP_SDR)) begin
            tdo_oe_nxt = 1'b1;
            unique case (dr_select(tst_r.ir))
                BSTP_SEL_ID: tdo_nxt = tst_r.id_sh[0];
                BSTP_SEL_BSR: tdo_nxt = tst_r.bsr_sh[0];
                default: tdo_nxt = tst_r.byp;
            endcase
        end
    end

    // tdo moves on the falling edge so the tester samples it on the rising one
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    // the only test port output
    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // extest and clamp drive from the latches, highz floats every covered pad
    assign pins_driven = scan_on && drives_pins(tst_r.ir);
    assign pins_floated = scan_on && (tst_r.ir == BSTP_IR_HIGHZ);

    // pad multiplexer; bypass, idcode, sample and reserved codes pass through
    always_comb begin
        pad_out = sys_out;
        pad_oe = sys_oe;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (pins_floated) begin
                pad_oe[p] = 1'b0;
            end else if (pins_driven) begin
                pad_oe[p] = tst_r.bsr_lat[cell_oe(p)];
                pad_out[p] = tst_r.bsr_lat[cell_out(p)];
            end
        end
    end

    // the system always sees its pads; sampling never disturbs it
    assign sys_in = pad_in;
endmodule
`default_nettype wire

// >>> test/bstp_tester.sv
// Purpose: board tester model driving the test port pins
// Assumes: tck period 64 ns, stopped between frames
// Notes: idle tdi sits high as its pull-up leaves it; tms starts high, then rests low in run-test-idle
`timescale 1ns/1ns
`default_nettype none
module bstp_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // one tck cycle at even duty; tdo taken at the rising edge
    task automatic clk(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #32;
        q = tdo;
        tck = 1'b1; // half period high
        #32;
        tck = 1'b0;
    endtask
    // hard reset pulses trst_n, soft reset uses six tms ones only
    task automatic rst(input logic hard);
        logic q;
        trst_n = ~hard;
        clk(1'b1, 1'b1, q);
        trst_n = 1'b1;
        repeat (5) clk(1'b1, 1'b1, q);
        clk(1'b0, 1'b1, q);
    endtask
    // idle to shift, n bits, update, back to idle with settle edges
    task automatic scan(input logic ir, input int n, input logic [381:0] din,
                        output logic [381:0] dout);
        logic q;
        dout = '0;
        clk(1'b1, 1'b1, q);
        if (ir) begin
            clk(1'b1, 1'b1, q);
        end
        clk(1'b0, 1'b1, q);
        clk(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            clk(i == n - 1, din[i], q); // low bit first
            dout[i] = q;
        end
        clk(1'b1, 1'b1, q); // exit1 to update
        repeat (3) clk(1'b0, 1'b1, q); // update to idle, then settle in idle
    endtask
endmodule
`default_nettype wire

// >>> test/bstp_top_chk.sv
// Purpose: port checker of the boundary-scan test port
// Assumes: bound onto bstp_top, pins steady between core_clk edges
// Notes: two domains, each property names its own clock
`timescale 1ns/1ns
`default_nettype none
module bstp_top_chk #(
    parameter int NUM_PINS = 126
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_reset_pin,
    input wire logic scan_enable_pin,
    input wire logic emulator_enable_pin,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic test_pins_owned,
    input wire logic [NUM_PINS-1:0] sys_out,
    input wire logic [NUM_PINS-1:0] sys_oe,
    input wire logic [NUM_PINS-1:0] sys_in,
    input wire logic [NUM_PINS-1:0] pad_in,
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe
);
    // enable condition of the scan logic, seen on core_clk
    sequence s_on;
        chip_reset_pin && scan_enable_pin && !emulator_enable_pin;
    endsequence
    sequence s_off;
        !(chip_reset_pin && scan_enable_pin && !emulator_enable_pin);
    endsequence
    a_owned_off: assert property (@(posedge core_clk) disable iff (reset)
        s_off [*3] |=> !test_pins_owned) else $error("test pins kept while disabled");
    a_owned_on: assert property (@(posedge core_clk) disable iff (reset)
        s_on [*4] |=> test_pins_owned) else $error("test pins not taken");
    a_owned_reset: assert property (@(posedge core_clk)
        reset |=> !test_pins_owned) else $error("test pins taken in reset");
    a_oe_needs_owned: assert property (@(posedge tck) disable iff (!trst_n)
        !test_pins_owned [*4] |-> !tdo_oe) else $error("tdo driven while disabled");
    a_tdo_idle_low: assert property (@(posedge tck) disable iff (!trst_n)
        !tdo_oe |-> tdo == 1'b0) else $error("tdo high while undriven");
    a_trst_quiet: assert property (@(posedge tck)
        !trst_n |-> !tdo_oe && tdo == 1'b0) else $error("tdo active in test reset");
    a_sys_in_pass: assert property (@(posedge core_clk) disable iff (reset)
        sys_in == pad_in) else $error("pad level not passed to core");
    a_pins_free_off: assert property (@(posedge tck) disable iff (!trst_n)
        !test_pins_owned [*4] |-> pad_oe == sys_oe && pad_out == sys_out)
        else $error("pads taken while disabled");
endmodule
`default_nettype wire

// >>> test/test_bstp_top.sv
// Purpose: self-checking bench of the boundary-scan test port
// Assumes: tester model owns the test pins, core_clk at 25 MHz
// Notes: pads stay still during scans so the pad samplers settle
`timescale 1ns/1ns
`default_nettype none
module test_bstp_top;
    import bstp_pkg::*;
    localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary value
    localparam int NP = 126;
    logic core_clk, reset, chip_reset_pin, scan_enable_pin, emulator_enable_pin;
    wire logic tck, tms, tdi, trst_n, tdo, tdo_oe, owned;
    logic [NP-1:0] sys_out, sys_oe, pad_in;
    wire logic [NP-1:0] sys_in, pad_out, pad_oe;
    logic [381:0] din, dout;
    logic [7:0] codes [3] = '{BSTP_IR_BYPASS, BSTP_IR_HIGHZ, 8'h3c};
    int seed, failures, n_tests;
    bstp_top #(.ID_VALUE(ID), .NUM_PINS(NP)) u_bstp_top (
        .core_clk(core_clk), .reset(reset), .chip_reset_pin(chip_reset_pin),
        .scan_enable_pin(scan_enable_pin), .emulator_enable_pin(emulator_enable_pin),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
        .test_pins_owned(owned), .sys_out(sys_out), .sys_oe(sys_oe), .sys_in(sys_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    bstp_tester u_bstp_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
    function automatic logic [381:0] rnd();
        logic [383:0] r;
        r = '0;
        for (int i = 0; i < 12; i++) begin
            r = {r[351:0], $random(seed)};
        end
        return r[381:0];
    endfunction
    // bypass shows a zero first, then tdi one clock late
    function automatic logic [15:0] byp(input logic [15:0] d);
        return {d[14:0], 1'b0};
    endfunction
    task automatic chk(input logic [381:0] got, input logic [381:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // cuts a hang well past the expected run of about 0.05 ms
    initial begin
        #500000;
        failures++;
        wrap_up();
    end
    initial begin
        seed = 32'h19bf5827;
        failures = 0;
        n_tests = 0;
        {reset, chip_reset_pin, scan_enable_pin, emulator_enable_pin} = 4'hf;
        {sys_out, sys_oe, pad_in} = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        din = rnd();
        sys_out = din[NP-1:0];
        din = rnd();
        sys_oe = din[NP-1:0];
        din = rnd();
        pad_in = din[NP-1:0];
        // each of the three disabling pin levels keeps the port off
        for (int k = 0; k < 3; k++) begin
            {chip_reset_pin, scan_enable_pin, emulator_enable_pin} = 3'b110 ^ (3'b100 >> k);
            repeat (4) @(negedge core_clk);
            chk(owned, 1'b0); // port stays off
        end
        u_bstp_tester.rst(1'b1);
        u_bstp_tester.scan(1'b0, 32, '0, dout);
        chk(dout, '0); // nothing shifts out
        chk({pad_out, pad_oe}, {sys_out, sys_oe}); // pads left to core
        @(negedge core_clk);
        {chip_reset_pin, scan_enable_pin, emulator_enable_pin} = 3'b110;
        repeat (4) @(negedge core_clk);
        chk(owned, 1'b1); // port takes its pins
        u_bstp_tester.rst(1'b1);
        u_bstp_tester.scan(1'b0, 32, '0, dout);
        chk(dout, ID); // id after test reset
        // bypass, floated pads and a reserved code all use the one-bit path
        foreach (codes[k]) begin
            din = rnd();
            u_bstp_tester.scan(1'b1, 8, codes[k], dout);
            chk(dout, 8'h01); // capture pattern
            u_bstp_tester.scan(1'b0, 16, din, dout);
            chk(dout, byp(din[15:0])); // one-bit path
            chk({pad_out, pad_oe}, {sys_out, (codes[k] == BSTP_IR_HIGHZ) ? {NP{1'b0}} : sys_oe});
        end
        u_bstp_tester.scan(1'b1, 8, BSTP_IR_SAMPLE, dout);
        din = rnd();
        u_bstp_tester.scan(1'b0, 382, din, dout);
        chk({dout[381:379], dout[5:3]}, {sys_out[125], sys_oe[125], pad_in[125],
            sys_out[0], sys_oe[0], pad_in[0]}); // cell layout
        chk({pad_out, pad_oe}, {sys_out, sys_oe}); // sample leaves pads
        // preloaded latches reach the pads under extest, then clamp
        u_bstp_tester.scan(1'b1, 8, BSTP_IR_EXTEST, dout);
        chk({pad_out[125], pad_oe[125], pad_out[0], pad_oe[0]}, {din[381:380], din[5:4]});
        u_bstp_tester.scan(1'b1, 8, BSTP_IR_CLAMP, dout);
        chk({pad_out[125], pad_oe[125], pad_out[0], pad_oe[0]}, {din[381:380], din[5:4]});
        u_bstp_tester.rst(1'b0);
        u_bstp_tester.scan(1'b0, 32, '0, dout);
        chk(dout, ID); // id after logic reset state
        chk({pad_out, pad_oe}, {sys_out, sys_oe}); // pads freed again
        wrap_up();
    end
endmodule
bind bstp_top bstp_top_chk #(.NUM_PINS(NUM_PINS)) u_bstp_top_chk (
    .core_clk(core_clk), .reset(reset), .chip_reset_pin(chip_reset_pin),
    .scan_enable_pin(scan_enable_pin), .emulator_enable_pin(emulator_enable_pin),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .test_pins_owned(test_pins_owned), .sys_out(sys_out), .sys_oe(sys_oe),
    .sys_in(sys_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
`default_nettype wire
